//--- inc/boot_loader_pkg.sv
// Constants and carrier types for the serial boot packet loader
package boot_loader_pkg;

  // Reply, sync and padding bytes
  localparam logic [7:0] ACK_BYTE  = 8'hcc;
  localparam logic [7:0] NAK_BYTE  = 8'h33;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [7:0] PAD_BYTE  = 8'h00;
  localparam logic [1:0] SYNC_LAST = 2'h1;

  // Command codes
  localparam logic [7:0] CMD_PING         = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD     = 8'h21;
  localparam logic [7:0] CMD_RUN          = 8'h22;
  localparam logic [7:0] status_query_cmd = 8'h23;
  localparam logic [7:0] CMD_DATA         = 8'h24;
  localparam logic [7:0] CMD_RESET        = 8'h25;

  // Packet lengths, length and sum bytes included; MAX_CHUNK counts chunk data bytes only
  localparam logic [7:0] HDR_BYTES    = 8'h02;
  localparam logic [7:0] MIN_LEN      = 8'h03;
  localparam logic [7:0] LEN_SHORT    = 8'h03;
  localparam logic [7:0] LEN_RUN      = 8'h07;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0b;
  localparam logic [7:0] MAX_CHUNK    = 8'h08;
  localparam int         DOC_MAX_LEN  = 11;

  // Last-command status codes
  localparam logic [7:0] STAT_SUCCESS = 8'h40;
  localparam logic [7:0] STAT_UNKNOWN = 8'h41;
  localparam logic [7:0] STAT_INVALID = 8'h42;
  localparam logic [7:0] STAT_BAD_ADR = 8'h43;
  localparam logic [7:0] STAT_FLASH   = 8'h44;

  // Response packet for the status query: ack, length, sum, status
  localparam logic [2:0] SEQ_ONE    = 3'h1;
  localparam logic [2:0] SEQ_STATUS = 3'h4;

  typedef enum logic [1:0] {
    FOP_NONE  = 2'b00,
    FOP_ERASE = 2'b01,
    FOP_PROG  = 2'b10
  } flash_op_t;

  typedef struct packed {
    flash_op_t   op;
    logic [31:0] addr;
    logic [31:0] size;
    logic [63:0] data;
    logic [3:0]  nbytes;
  } flash_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_t;

  typedef enum logic [1:0] {
    LINK_NONE = 2'b00,
    LINK_UART = 2'b01,
    LINK_SSI  = 2'b10
  } link_sel_t;

  typedef enum logic [1:0] {
    POST_IDLE  = 2'b00,
    POST_HACK  = 2'b01,
    POST_RUN   = 2'b10,
    POST_RESET = 2'b11
  } post_t;

  typedef enum logic [3:0] {
    S_LEN   = 4'h0,
    S_SUM   = 4'h1,
    S_DATA  = 4'h2,
    S_EXEC  = 4'h3,
    S_FLASH = 4'h4,
    S_TX    = 4'h5,
    S_HACK  = 4'h6,
    S_DRAIN = 4'h7
  } state_t;

endpackage

//--- rtl/serial_boot_packet_loader.sv
// Packet framing and command interpreter of the serial boot loader
`timescale 1ns/1ps

module serial_boot_packet_loader #(
  parameter int          MAX_LEN     = 11,
  parameter logic [31:0] FLASH_BYTES = 32'h0004_0000,
  parameter int          TXQ_DEPTH   = 2
) (
  input  wire logic                         CLK_I,
  input  wire logic                         RST_B_I,
  input  wire boot_loader_pkg::byte_beat_t  UART_RX_I,
  output      logic                         UART_RX_READY_O,
  output      boot_loader_pkg::byte_beat_t  UART_TX_O,
  input  wire logic                         UART_TX_READY_I,
  input  wire boot_loader_pkg::byte_beat_t  SSI_RX_I,
  output      logic                         SSI_RX_READY_O,
  output      boot_loader_pkg::byte_beat_t  SSI_TX_O,
  input  wire logic                         SSI_TX_READY_I,
  output      logic                         FLASH_START_O,
  output      boot_loader_pkg::flash_req_t  FLASH_REQ_O,
  input  wire logic                         FLASH_DONE_I,
  input  wire logic                         FLASH_ERR_I,
  output      logic                         RUN_O,
  output      logic [31:0]                  RUN_ADDR_O,
  output      logic                         SOFT_RESET_O,
  output      logic [1:0]                   LINK_SEL_O
);

  localparam int MAX_PAY = MAX_LEN - 2;
  localparam int PW      = $clog2(MAX_PAY);
  localparam int QW      = $clog2(TXQ_DEPTH);

  if (MAX_LEN < boot_loader_pkg::DOC_MAX_LEN || MAX_LEN > 255) begin : g_chk_len
    $error("MAX_LEN must lie between 11 and 255");
  end
  if (TXQ_DEPTH < 2 || (TXQ_DEPTH & (TXQ_DEPTH - 1)) != 0) begin : g_chk_q
    $error("TXQ_DEPTH must be a power of two, at least 2");
  end

  boot_loader_pkg::state_t     state_q;
  boot_loader_pkg::link_sel_t  sel_q;
  boot_loader_pkg::post_t      post_q;
  boot_loader_pkg::flash_req_t flash_q;
  logic [1:0]                  sync_cnt_q;
  logic [7:0]                  len_q;
  logic [7:0]                  sum_q;
  logic [7:0]                  calc_q;
  logic [7:0]                  cnt_q;
  logic [7:0]                  pl_q [MAX_PAY];
  logic [7:0]                  status_q;
  logic [31:0]                 prog_addr_q;
  logic [31:0]                 remain_q;
  logic                        session_q;
  logic [7:0]                  seq_q [4];
  logic [2:0]                  seq_len_q;
  logic [2:0]                  seq_idx_q;
  logic                        start_q;
  logic                        run_q;
  logic [31:0]                 run_addr_q;
  logic                        soft_rst_q;

  logic [7:0]                  q_mem [TXQ_DEPTH];
  logic [QW-1:0]               q_wr_q;
  logic [QW-1:0]               q_rd_q;
  logic [QW:0]                 q_cnt_q;

  logic                        rx_v;
  logic [7:0]                  rx_d;
  logic                        rx_rdy;
  logic                        take;
  logic                        sync_hit;
  logic                        q_in_ready;
  logic                        q_push;
  logic                        q_out_valid;
  logic                        q_pop;
  logic                        tx_rdy;
  logic [7:0]                  chunk_n;
  logic [31:0]                 arg_a;
  logic [31:0]                 arg_b;
  logic [32:0]                 region_end;
  logic [63:0]                 chunk_data;

  // Receive side: byte source follows the locked interface
  always_comb begin
    rx_rdy = (state_q == boot_loader_pkg::S_LEN) ||
             (state_q == boot_loader_pkg::S_SUM) ||
             (state_q == boot_loader_pkg::S_DATA) ||
             (state_q == boot_loader_pkg::S_HACK);
    sync_hit = (sel_q == boot_loader_pkg::LINK_NONE) &&
               (state_q == boot_loader_pkg::S_LEN) && UART_RX_I.valid &&
               (UART_RX_I.data == boot_loader_pkg::SYNC_BYTE) &&
               (sync_cnt_q == boot_loader_pkg::SYNC_LAST);
    if (sel_q == boot_loader_pkg::LINK_UART) begin
      rx_v = UART_RX_I.valid;
      rx_d = UART_RX_I.data;
    end else begin
      rx_v = SSI_RX_I.valid;
      rx_d = SSI_RX_I.data;
    end
    take = rx_v && rx_rdy && !sync_hit;
  end

  // The idle interface is drained and discarded once one is locked
  always_comb begin
    case (sel_q)
      boot_loader_pkg::LINK_UART: begin
        UART_RX_READY_O = rx_rdy;
        SSI_RX_READY_O  = 1'b1;
      end
      boot_loader_pkg::LINK_SSI: begin
        UART_RX_READY_O = 1'b1;
        SSI_RX_READY_O  = rx_rdy;
      end
      default: begin
        UART_RX_READY_O = (state_q == boot_loader_pkg::S_LEN);
        SSI_RX_READY_O  = rx_rdy && !sync_hit;
      end
    endcase
  end

  // Interface lock and rate-detection pattern
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sel_q      <= boot_loader_pkg::LINK_NONE;
      sync_cnt_q <= 2'h0;
    end else if (sel_q == boot_loader_pkg::LINK_NONE) begin
      if (sync_hit) begin
        sel_q <= boot_loader_pkg::LINK_UART;
      end else if (take && rx_d != boot_loader_pkg::PAD_BYTE) begin
        sel_q <= boot_loader_pkg::LINK_SSI;
      end
      if (state_q == boot_loader_pkg::S_LEN && UART_RX_I.valid) begin
        if (UART_RX_I.data == boot_loader_pkg::SYNC_BYTE) begin
          sync_cnt_q <= sync_cnt_q + 2'h1;
        end else begin
          sync_cnt_q <= 2'h0;
        end
      end
    end
  end

  // Command parameter fields, most significant byte first
  always_comb begin
    arg_a      = {pl_q[1], pl_q[2], pl_q[3], pl_q[4]};
    arg_b      = {pl_q[5], pl_q[6], pl_q[7], pl_q[8]};
    chunk_n    = len_q - boot_loader_pkg::LEN_SHORT;
    region_end = {1'b0, arg_a} + {1'b0, arg_b};
  end

  for (genvar g = 0; g < 8; g++) begin : g_chunk
    assign chunk_data[g*8 +: 8] = pl_q[g+1];
  end

  // Packet framing and command execution
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q     <= boot_loader_pkg::S_LEN;
      post_q      <= boot_loader_pkg::POST_IDLE;
      len_q       <= 8'h00;
      sum_q       <= 8'h00;
      calc_q      <= 8'h00;
      cnt_q       <= 8'h00;
      status_q    <= boot_loader_pkg::STAT_SUCCESS;
      prog_addr_q <= 32'h0000_0000;
      remain_q    <= 32'h0000_0000;
      session_q   <= 1'b0;
      seq_len_q   <= boot_loader_pkg::SEQ_ONE;
      seq_idx_q   <= 3'h0;
      flash_q     <= '0;
      start_q     <= 1'b0;
      run_q       <= 1'b0;
      run_addr_q  <= 32'h0000_0000;
      soft_rst_q  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        seq_q[i] <= 8'h00;
      end
      for (int i = 0; i < MAX_PAY; i++) begin
        pl_q[i] <= 8'h00;
      end
    end else begin
      start_q    <= 1'b0;
      run_q      <= 1'b0;
      soft_rst_q <= 1'b0;
      case (state_q)
        boot_loader_pkg::S_LEN: begin
          if (sync_hit) begin
            seq_q[0]  <= boot_loader_pkg::ACK_BYTE;
            seq_len_q <= boot_loader_pkg::SEQ_ONE;
            seq_idx_q <= 3'h0;
            post_q    <= boot_loader_pkg::POST_IDLE;
            state_q   <= boot_loader_pkg::S_TX;
          end else if (take && rx_d != boot_loader_pkg::PAD_BYTE) begin
            len_q  <= rx_d;
            calc_q <= 8'h00;
            cnt_q  <= 8'h00;
            if (rx_d < boot_loader_pkg::MIN_LEN) begin
              // Too short to carry a command; nothing to wait for
              seq_q[0]  <= boot_loader_pkg::NAK_BYTE;
              seq_len_q <= boot_loader_pkg::SEQ_ONE;
              seq_idx_q <= 3'h0;
              post_q    <= boot_loader_pkg::POST_IDLE;
              state_q   <= boot_loader_pkg::S_TX;
            end else begin
              state_q <= boot_loader_pkg::S_SUM;
            end
          end
        end
        boot_loader_pkg::S_SUM: begin
          if (take) begin
            sum_q   <= rx_d;
            state_q <= boot_loader_pkg::S_DATA;
          end
        end
        boot_loader_pkg::S_DATA: begin
          if (take) begin
            calc_q <= calc_q + rx_d;
            if (cnt_q < 8'(MAX_PAY)) begin
              pl_q[cnt_q[PW-1:0]] <= rx_d;
            end
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == len_q - boot_loader_pkg::MIN_LEN) begin
              state_q <= boot_loader_pkg::S_EXEC;
            end
          end
        end
        boot_loader_pkg::S_EXEC: begin
          seq_idx_q <= 3'h0;
          seq_len_q <= boot_loader_pkg::SEQ_ONE;
          post_q    <= boot_loader_pkg::POST_IDLE;
          state_q   <= boot_loader_pkg::S_TX;
          if (calc_q != sum_q) begin
            // Rejected packets touch neither status nor address
            seq_q[0] <= boot_loader_pkg::NAK_BYTE;
          end else begin
            seq_q[0] <= boot_loader_pkg::ACK_BYTE;
            if (len_q > 8'(MAX_LEN)) begin
              status_q <= boot_loader_pkg::STAT_INVALID;
            end else begin
              case (pl_q[0])
                boot_loader_pkg::CMD_PING: begin
                  status_q <= boot_loader_pkg::STAT_SUCCESS;
                end
                boot_loader_pkg::status_query_cmd: begin
                  seq_q[1]  <= boot_loader_pkg::MIN_LEN;
                  seq_q[2]  <= status_q;
                  seq_q[3]  <= status_q;
                  seq_len_q <= boot_loader_pkg::SEQ_STATUS;
                  post_q    <= boot_loader_pkg::POST_HACK;
                end
                boot_loader_pkg::CMD_DOWNLOAD: begin
                  session_q <= 1'b0;
                  if (len_q != boot_loader_pkg::LEN_DOWNLOAD) begin
                    status_q <= boot_loader_pkg::STAT_INVALID;
                  end else if (arg_b == 32'h0000_0000 ||
                               region_end > {1'b0, FLASH_BYTES}) begin
                    status_q <= boot_loader_pkg::STAT_BAD_ADR;
                  end else begin
                    prog_addr_q    <= arg_a;
                    remain_q       <= arg_b;
                    flash_q.op     <= boot_loader_pkg::FOP_ERASE;
                    flash_q.addr   <= arg_a;
                    flash_q.size   <= arg_b;
                    flash_q.nbytes <= 4'h0;
                    start_q        <= 1'b1;
                    state_q        <= boot_loader_pkg::S_FLASH;
                  end
                end
                boot_loader_pkg::CMD_DATA: begin
                  if (!session_q || chunk_n == 8'h00 ||
                      chunk_n > boot_loader_pkg::MAX_CHUNK ||
                      {24'h00_0000, chunk_n} > remain_q) begin
                    status_q <= boot_loader_pkg::STAT_INVALID;
                  end else begin
                    flash_q.op     <= boot_loader_pkg::FOP_PROG;
                    flash_q.addr   <= prog_addr_q;
                    flash_q.size   <= {24'h00_0000, chunk_n};
                    flash_q.data   <= chunk_data;
                    flash_q.nbytes <= chunk_n[3:0];
                    start_q        <= 1'b1;
                    state_q        <= boot_loader_pkg::S_FLASH;
                  end
                end
                boot_loader_pkg::CMD_RUN: begin
                  if (len_q == boot_loader_pkg::LEN_RUN) begin
                    run_addr_q <= arg_a;
                    status_q   <= boot_loader_pkg::STAT_SUCCESS;
                    post_q     <= boot_loader_pkg::POST_RUN;
                  end else begin
                    status_q <= boot_loader_pkg::STAT_INVALID;
                  end
                end
                boot_loader_pkg::CMD_RESET: begin
                  status_q <= boot_loader_pkg::STAT_SUCCESS;
                  post_q   <= boot_loader_pkg::POST_RESET;
                end
                default: begin
                  status_q <= boot_loader_pkg::STAT_UNKNOWN;
                end
              endcase
            end
          end
        end
        boot_loader_pkg::S_FLASH: begin
          // Reply is held back until the flash engine finishes
          if (FLASH_DONE_I) begin
            seq_q[0] <= boot_loader_pkg::ACK_BYTE;
            state_q  <= boot_loader_pkg::S_TX;
            if (FLASH_ERR_I) begin
              status_q  <= boot_loader_pkg::STAT_FLASH;
              session_q <= 1'b0;
            end else begin
              status_q <= boot_loader_pkg::STAT_SUCCESS;
              if (flash_q.op == boot_loader_pkg::FOP_ERASE) begin
                session_q <= 1'b1;
              end else begin
                prog_addr_q <= prog_addr_q + flash_q.size;
                remain_q    <= remain_q - flash_q.size;
                session_q   <= (remain_q != flash_q.size);
              end
            end
          end
        end
        boot_loader_pkg::S_TX: begin
          if (q_in_ready) begin
            seq_idx_q <= seq_idx_q + 3'h1;
            if (seq_idx_q == seq_len_q - 3'h1) begin
              case (post_q)
                boot_loader_pkg::POST_HACK:
                  state_q <= boot_loader_pkg::S_HACK;
                boot_loader_pkg::POST_RUN,
                boot_loader_pkg::POST_RESET:
                  state_q <= boot_loader_pkg::S_DRAIN;
                default:
                  state_q <= boot_loader_pkg::S_LEN;
              endcase
            end
          end
        end
        boot_loader_pkg::S_HACK: begin
          // Ack and nak both close the exchange; the host retries
          if (take && rx_d != boot_loader_pkg::PAD_BYTE) begin
            state_q <= boot_loader_pkg::S_LEN;
          end
        end
        boot_loader_pkg::S_DRAIN: begin
          if (!q_out_valid) begin
            run_q      <= (post_q == boot_loader_pkg::POST_RUN);
            soft_rst_q <= (post_q == boot_loader_pkg::POST_RESET);
            state_q    <= boot_loader_pkg::S_LEN;
          end
        end
        default: begin
          state_q <= boot_loader_pkg::S_LEN;
        end
      endcase
    end
  end

  // Outgoing byte buffer; absorbs stalls so a packet leaves unbroken
  assign q_push      = (state_q == boot_loader_pkg::S_TX) && q_in_ready;
  assign q_in_ready  = (q_cnt_q != (QW + 1)'(TXQ_DEPTH));
  assign q_out_valid = (q_cnt_q != '0);
  assign tx_rdy      = (sel_q == boot_loader_pkg::LINK_SSI) ? SSI_TX_READY_I
                                                            : UART_TX_READY_I;
  assign q_pop       = q_out_valid && tx_rdy;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q_wr_q  <= '0;
      q_rd_q  <= '0;
      q_cnt_q <= '0;
      for (int i = 0; i < TXQ_DEPTH; i++) begin
        q_mem[i] <= 8'h00;
      end
    end else begin
      if (q_push) begin
        q_mem[q_wr_q] <= seq_q[seq_idx_q[1:0]];
        q_wr_q        <= q_wr_q + 1'b1;
      end
      if (q_pop) begin
        q_rd_q <= q_rd_q + 1'b1;
      end
      case ({q_push, q_pop})
        2'b10:   q_cnt_q <= q_cnt_q + 1'b1;
        2'b01:   q_cnt_q <= q_cnt_q - 1'b1;
        default: q_cnt_q <= q_cnt_q;
      endcase
    end
  end

  always_comb begin
    UART_TX_O.data  = q_mem[q_rd_q];
    SSI_TX_O.data   = q_mem[q_rd_q];
    UART_TX_O.valid = q_out_valid && (sel_q != boot_loader_pkg::LINK_SSI);
    SSI_TX_O.valid  = q_out_valid && (sel_q == boot_loader_pkg::LINK_SSI);
  end

  assign FLASH_START_O = start_q;
  assign FLASH_REQ_O   = flash_q;
  assign RUN_O         = run_q;
  assign RUN_ADDR_O    = run_addr_q;
  assign SOFT_RESET_O  = soft_rst_q;
  assign LINK_SEL_O    = sel_q;

endmodule

//--- test/loader_chk.sv
// Assertions on the loader's flash, reply and lock outputs
`timescale 1ns/1ps
module loader_chk (
  input wire logic                        CLK_I,
  input wire logic                        RST_B_I,
  input wire logic                        UART_RX_READY_O,
  input wire boot_loader_pkg::byte_beat_t UART_TX_O,
  input wire boot_loader_pkg::byte_beat_t SSI_TX_O,
  input wire logic                        SSI_TX_READY_I,
  input wire logic                        FLASH_START_O,
  input wire boot_loader_pkg::flash_req_t FLASH_REQ_O,
  input wire logic                        FLASH_DONE_I,
  input wire logic                        RUN_O,
  input wire logic                        SOFT_RESET_O,
  input wire logic [1:0]                  LINK_SEL_O
);
  logic busy_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Open flash operation, from start pulse to done
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      busy_q <= 1'b0;
    end else if (FLASH_START_O) begin
      busy_q <= 1'b1;
    end else if (FLASH_DONE_I) begin
      busy_q <= 1'b0;
    end
  end
  start_pulse_a: assert property (FLASH_START_O |=> !FLASH_START_O)
    else $error("flash start pulse too long");
  req_hold_a: assert property (busy_q |-> $stable(FLASH_REQ_O))
    else $error("flash request moved while busy");
  one_op_a: assert property (busy_q |-> !FLASH_START_O)
    else $error("flash start while busy");
  tx_hold_a: assert property (SSI_TX_O.valid && !SSI_TX_READY_I
    |=> SSI_TX_O.valid && $stable(SSI_TX_O.data))
    else $error("reply byte dropped or changed");
  run_after_a: assert property (RUN_O |-> !SSI_TX_O.valid ##1 !RUN_O)
    else $error("run before reply drained");
  restart_after_a: assert property (SOFT_RESET_O
    |-> !SSI_TX_O.valid && !UART_TX_O.valid ##1 !SOFT_RESET_O)
    else $error("restart before reply drained");
  lock_keep_a: assert property (LINK_SEL_O != 2'h0 |=> $stable(LINK_SEL_O))
    else $error("link lock changed");
  uart_off_a: assert property (LINK_SEL_O == 2'h2
    |-> UART_RX_READY_O && !UART_TX_O.valid)
    else $error("async port active while locked out");
endmodule
bind serial_boot_packet_loader loader_chk u_chk (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .UART_RX_READY_O(UART_RX_READY_O),
  .UART_TX_O(UART_TX_O), .SSI_TX_O(SSI_TX_O),
  .SSI_TX_READY_I(SSI_TX_READY_I), .FLASH_START_O(FLASH_START_O),
  .FLASH_REQ_O(FLASH_REQ_O), .FLASH_DONE_I(FLASH_DONE_I), .RUN_O(RUN_O),
  .SOFT_RESET_O(SOFT_RESET_O), .LINK_SEL_O(LINK_SEL_O));

//--- test/host_model.sv
// Host on the synchronous serial byte port
`timescale 1ns/1ps
module host_model (
  input  wire logic                        clk_i,
  output      boot_loader_pkg::byte_beat_t rx_o,
  input  wire logic                        rx_ready_i,
  input  wire boot_loader_pkg::byte_beat_t tx_i,
  output      logic                        tx_ready_o
);
  int slow = 0;
  initial begin
    rx_o = '0;
    tx_ready_o = 1'b0;
  end
  // Released line shows the inverse, never the old byte
  task automatic put(input logic [7:0] b);
    @(negedge clk_i);
    rx_o = {1'b1, b};
    @(posedge clk_i);
    while (!rx_ready_i) @(posedge clk_i);
    @(negedge clk_i);
    rx_o = {1'b0, ~b};
  endtask
  // Zero fill skipped; slow holds ready low to stall the reply buffer
  task automatic get(output logic [7:0] b);
    int n;
    b = 8'h00;
    for (n = 0; n < 400 && b == 8'h00; n++) begin
      @(negedge clk_i);
      tx_ready_o = (n >= slow);
      @(posedge clk_i);
      if (tx_ready_o && tx_i.valid) b = tx_i.data;
    end
    @(negedge clk_i);
    tx_ready_o = 1'b0;
  endtask
endmodule

//--- test/serial_boot_packet_loader_test.sv
// Self-checking bench for the serial boot packet loader
`timescale 1ns/1ps
module serial_boot_packet_loader_test;
  typedef logic [7:0] bq_t[$];
  localparam logic [7:0] ACK = boot_loader_pkg::ACK_BYTE;
  localparam logic [7:0] NAK = boot_loader_pkg::NAK_BYTE;
  logic                        clk = 1'b0;
  logic                        rst_b = 1'b0;
  logic                        done = 1'b0;
  int                          fcnt = 0;
  int                          bad_count = 0;
  int                          checked = 0;
  int                          cyc = 0;
  boot_loader_pkg::byte_beat_t ssi_rx, ssi_tx, uart_tx;
  boot_loader_pkg::flash_req_t req, lreq;
  logic                        ssi_rdy, tx_rdy, uart_rdy, start, run, sres;
  logic [31:0]                 run_adr;
  logic [1:0]                  sel;
  // Async port stays idle until the lock scenario after a mid-run reset
  boot_loader_pkg::byte_beat_t uart_rx = '0;
  logic                        uart_trdy = 1'b0;
  always #2.5 clk = ~clk;
  serial_boot_packet_loader DUT (
    .CLK_I(clk), .RST_B_I(rst_b), .UART_RX_I(uart_rx),
    .UART_RX_READY_O(uart_rdy), .UART_TX_O(uart_tx),
    .UART_TX_READY_I(uart_trdy), .SSI_RX_I(ssi_rx), .SSI_RX_READY_O(ssi_rdy),
    .SSI_TX_O(ssi_tx), .SSI_TX_READY_I(tx_rdy), .FLASH_START_O(start),
    .FLASH_REQ_O(req), .FLASH_DONE_I(done), .FLASH_ERR_I(1'b0),
    .RUN_O(run), .RUN_ADDR_O(run_adr), .SOFT_RESET_O(sres),
    .LINK_SEL_O(sel));
  host_model host (.clk_i(clk), .rx_o(ssi_rx), .rx_ready_i(ssi_rdy),
    .tx_i(ssi_tx), .tx_ready_o(tx_rdy));
  // Flash engine stand-in: done a few cycles after each start
  always @(negedge clk) begin
    done <= 1'b0;
    if (start) begin
      fcnt <= 6;
      lreq <= req;
    end else if (fcnt == 1) begin
      done <= 1'b1;
      fcnt <= 0;
    end else if (fcnt > 0) begin
      fcnt <= fcnt - 1;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wrong sum forced when a refusal is expected
  task automatic send(input bq_t d, input logic [7:0] exp);
    logic [7:0] s;
    logic [7:0] r;
    s = 8'h00;
    foreach (d[i]) s += d[i];
    host.put(8'(d.size() + 2));
    host.put(exp == ACK ? s : s + 8'h01);
    foreach (d[i]) host.put(d[i]);
    host.get(r);
    chk(r, exp);
  endtask
  task automatic stat(input logic [7:0] st);
    logic [7:0] r;
    send('{boot_loader_pkg::status_query_cmd}, ACK);
    host.get(r);
    chk(r, 8'h03);
    host.get(r);
    chk(r, st);
    host.get(r);
    chk(r, st);
    host.put(8'h00);
    host.put(ACK);
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; n < 50 && s !== 1'b1; n++) @(negedge clk);
    chk(s, 1'b1);
  endtask
  task automatic t_ping();
    send('{8'h20}, ACK);
    chk(sel, 2'h2);
    stat(8'h40);
  endtask
  task automatic t_bad();
    send('{8'h20}, NAK);
    send('{8'h30}, ACK);
    stat(8'h41);
  endtask
  task automatic t_prog();
    send('{8'h21, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08}, ACK);
    chk(lreq.op, boot_loader_pkg::FOP_ERASE);
    chk(lreq.addr, 32'h0000_0100);
    chk(lreq.size, 32'h0000_0008);
    stat(8'h40);
    host.slow = 3;
    send('{8'h24, 8'h11, 8'h22, 8'h33, 8'h44}, NAK);
    chk(lreq.op, boot_loader_pkg::FOP_ERASE);
    send('{8'h24, 8'h11, 8'h22, 8'h33, 8'h44}, ACK);
    chk(lreq.addr, 32'h0000_0100);
    chk(lreq.data[31:0], 32'h4433_2211);
    send('{8'h24, 8'h55, 8'h66, 8'h77, 8'h88}, ACK);
    chk(lreq.addr, 32'h0000_0104);
    host.slow = 0;
    stat(8'h40);
    send('{8'h24, 8'h99}, ACK);
    stat(8'h42);
  endtask
  task automatic t_run();
    send('{8'h22, 8'h00, 8'h00, 8'h02, 8'h00}, ACK);
    wait_hi(run);
    chk(run_adr, 32'h0000_0200);
  endtask
  task automatic t_restart();
    send('{8'h25}, ACK);
    wait_hi(sres);
  endtask
  // Reset clears the lock, then two 0x55 bytes lock the async port
  task automatic t_sync();
    int n;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    uart_rx = {1'b1, boot_loader_pkg::SYNC_BYTE};
    repeat (2) @(negedge clk);
    uart_rx = '0;
    chk(sel, 2'h1);
    uart_trdy = 1'b1;
    for (n = 0; n < 10 && uart_tx.valid !== 1'b1; n++) @(negedge clk);
    chk(uart_tx.valid, 1'b1);
    chk(uart_tx.data, ACK);
    @(negedge clk);
    uart_trdy = 1'b0;
    chk(uart_tx.valid, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_ping();
    t_bad();
    t_prog();
    t_run();
    t_restart();
    t_sync();
    end_sim();
  end
endmodule
